/* logic/fam_pkg.sv */
// shared constants and types for the algorithm monitor register bank
package fam_pkg;

   // ****************************************
   // bus geometry
   // ****************************************
   localparam int ADDR_W = 14;
   localparam int DATA_W = 32;
   localparam int NREG = 9;

   // ****************************************
   // register indices (byte address is four times the index)
   // ****************************************
   localparam logic [11:0] IDX_CL_REF = 12'h5d0;
   localparam logic [11:0] IDX_FLUX_REF = 12'h60a;
   localparam logic [11:0] IDX_TORQUE_REF = 12'h60c;
   localparam logic [11:0] IDX_SD_STATE = 12'h6b0;
   localparam logic [11:0] IDX_SD_SPEED = 12'h6ba;
   localparam logic [11:0] IDX_PD_STATE = 12'h6e4;
   localparam logic [11:0] IDX_PD_ANGLE = 12'h71a;
   localparam logic [11:0] IDX_CTRL = 12'h7f0;
   localparam logic [11:0] IDX_STATUS = 12'h7f2;

   // read mux slot of each register
   localparam int SLOT_CL_REF = 0;
   localparam int SLOT_CTRL = 7;
   localparam logic [11:0] REG_IDX [NREG] = '{
      IDX_CL_REF, IDX_FLUX_REF, IDX_TORQUE_REF, IDX_SD_STATE, IDX_SD_SPEED,
      IDX_PD_STATE, IDX_PD_ANGLE, IDX_CTRL, IDX_STATUS};

   // ****************************************
   // reset values and fields
   // ****************************************
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [15:0] RST_CODE = 16'h0000;
   localparam logic RST_FREEZE = 1'b0;
   localparam int CTRL_FREEZE_BIT = 0;
   localparam int STAT_SD_DONE_BIT = 0;
   localparam int STAT_SD_ERR_BIT = 1;
   localparam int STAT_PD_DONE_BIT = 2;
   localparam int STAT_PD_ERR_BIT = 3;
   localparam int STAT_FREEZE_BIT = 4;
   localparam int STAT_MODE_LSB = 8;

   // ****************************************
   // control modes and sequencer codes
   // ****************************************
   typedef enum logic [1:0] {
      MODE_SPEED = 2'h0,
      MODE_POWER = 2'h1,
      MODE_CURRENT = 2'h2
   } fam_mode_type;

   typedef enum logic [15:0] {
      SD_INIT = 16'h0000,
      SD_STOP_CHECK = 16'h0001,
      SD_ESTIM_INIT = 16'h0002,
      SD_RUN_CHECK = 16'h0003,
      SD_DIR_CHECK = 16'h0004,
      SD_COMPLETE = 16'h0005,
      SD_FAULT = 16'h0006
   } fam_sd_state_type;

   typedef enum logic [15:0] {
      PD_INIT = 16'h0000,
      PD_VECTOR_CONFIG = 16'h0001,
      PD_RUN = 16'h0002,
      PD_SLOW_RISE = 16'h0003,
      PD_SLOW_FALL = 16'h0004,
      PD_WAIT_DECAY = 16'h0005,
      PD_GET_TIMES = 16'h0006,
      PD_SET_NEXT_VECTOR = 16'h0007,
      PD_CALC_SECTOR_RISE = 16'h0008,
      PD_CALC_ROTOR_POS = 16'h0009,
      PD_CALC_ANGLE = 16'h000a,
      PD_COMPLETE = 16'h000b,
      PD_FAULT = 16'h000c
   } fam_pd_state_type;

   // ****************************************
   // sample from the control algorithm
   // ****************************************
   typedef struct packed {
      logic [1:0] mode;
      logic ref_valid;
      logic [31:0] speed_ref;
      logic [31:0] power_ref;
      logic [31:0] current_ref;
      logic [31:0] flux_ref;
      logic [31:0] torque_ref;
      logic sd_valid;
      logic [15:0] sd_state;
      logic [31:0] sd_speed;
      logic pd_valid;
      logic [15:0] pd_state;
      logic [31:0] pd_angle;
   } fam_algo_type;

endpackage : fam_pkg

/* logic/fam_state_code.sv */
// holds one sequencer state code and decodes its done and error codes
`timescale 1ns/100ps
module fam_state_code #(
   parameter logic [15:0] LAST_CODE = 16'h0006,
   parameter logic [15:0] DONE_CODE = 16'h0005,
   parameter logic [15:0] FAULT_CODE = 16'h0006
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [15:0] code_in,
   output logic [15:0] code_reg,
   output logic done,
   output logic error
);
   import fam_pkg::*;

   // an unknown code from the sequencer is shown as its fault code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_reg <= RST_CODE;
      end else if (load) begin
         code_reg <= (code_in > LAST_CODE) ? FAULT_CODE : code_in;
      end
   end

   assign done = (code_reg == DONE_CODE);
   assign error = (code_reg == FAULT_CODE);

endmodule : fam_state_code

/* logic/fam_magnitude.sv */
// registers the absolute magnitude of a signed 32-bit sample
`timescale 1ns/100ps
module fam_magnitude (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [31:0] value_in,
   output logic [31:0] mag_reg
);
   import fam_pkg::*;

   // the most negative input maps to 2^31, which is right when read unsigned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mag_reg <= RST_WORD;
      end else if (load) begin
         mag_reg <= value_in[31] ? (~value_in + 32'h0000_0001) : value_in;
      end
   end

endmodule : fam_magnitude

/* logic/fam_monitor_regs.sv */
// algorithm monitor register bank with an apb slave port
`timescale 1ns/100ps
module fam_monitor_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fam_pkg::ADDR_W-1:0] paddr,
   input wire logic [fam_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [fam_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire fam_pkg::fam_algo_type algo,
   output logic speed_detect_done,
   output logic speed_detect_error,
   output logic position_detect_done,
   output logic position_detect_error
);
   import fam_pkg::*;

   // ****************************************
   // state
   // ****************************************
   logic [31:0] cl_ref_reg;
   logic [31:0] flux_ref_reg;
   logic [31:0] torque_ref_reg;
   logic [31:0] sd_speed_reg;
   logic [31:0] pd_angle_reg;
   logic [15:0] sd_state_reg;
   logic [15:0] pd_state_reg;
   logic freeze_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic [31:0] status_word;
   logic [31:0] rd_next;
   logic [NREG-1:0] hit;
   logic [31:0] rd_word [NREG];
   logic aligned;
   logic setup;
   logic access;
   logic ctrl_wr;
   logic take_ref;
   logic take_sd;
   logic take_pd;

   // ****************************************
   // apb decode
   // ****************************************
   // zero wait states: every access phase completes on its first edge
   assign pready = 1'b1;
   assign setup = psel & ~penable;
   assign access = psel & penable & pready;
   assign aligned = (paddr[1:0] == 2'b00);

   generate
      for (genvar i = 0; i < NREG; i++) begin : g_hit
         assign hit[i] = aligned & (paddr[ADDR_W-1:2] == REG_IDX[i]);
      end
   endgenerate

   always_comb begin
      rd_next = RST_WORD;
      for (int i = 0; i < NREG; i++) begin
         if (hit[i]) begin
            rd_next = rd_next | rd_word[i];
         end
      end
   end

   assign rd_word[0] = cl_ref_reg;
   assign rd_word[1] = flux_ref_reg;
   assign rd_word[2] = torque_ref_reg;
   assign rd_word[3] = {16'h0000, sd_state_reg};
   assign rd_word[4] = sd_speed_reg;
   assign rd_word[5] = {16'h0000, pd_state_reg};
   assign rd_word[6] = pd_angle_reg;
   assign rd_word[7] = {31'h0000_0000, freeze_reg};
   assign rd_word[8] = status_word;

   always_comb begin
      status_word = RST_WORD;
      status_word[STAT_SD_DONE_BIT] = speed_detect_done;
      status_word[STAT_SD_ERR_BIT] = speed_detect_error;
      status_word[STAT_PD_DONE_BIT] = position_detect_done;
      status_word[STAT_PD_ERR_BIT] = position_detect_error;
      status_word[STAT_FREEZE_BIT] = freeze_reg;
      status_word[STAT_MODE_LSB +: 2] = algo.mode;
   end

   // read data is captured in the setup cycle so it leaves a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= RST_WORD;
      end else if (setup) begin
         prdata_reg <= pwrite ? RST_WORD : rd_next;
      end
   end

   // only an unmapped or misaligned address is an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         pslverr_reg <= ~|hit;
      end
   end

   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg & access;

   // ****************************************
   // control register
   // ****************************************
   // writes reach only this register, every monitor word is left alone
   assign ctrl_wr = access & pwrite & hit[SLOT_CTRL] & pstrb[0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freeze_reg <= RST_FREEZE;
      end else if (ctrl_wr) begin
         freeze_reg <= pwdata[CTRL_FREEZE_BIT];
      end
   end

   // freeze lets software read a coherent set; updates during it are lost
   assign take_ref = algo.ref_valid & ~freeze_reg;
   assign take_sd = algo.sd_valid & ~freeze_reg;
   assign take_pd = algo.pd_valid & ~freeze_reg;

   // ****************************************
   // references
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cl_ref_reg <= RST_WORD;
      end else if (take_ref) begin
         unique case (algo.mode)
            MODE_SPEED: cl_ref_reg <= algo.speed_ref;
            MODE_POWER: cl_ref_reg <= algo.power_ref;
            MODE_CURRENT: cl_ref_reg <= algo.current_ref;
            default: cl_ref_reg <= cl_ref_reg;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flux_ref_reg <= RST_WORD;
      end else if (take_ref) begin
         flux_ref_reg <= algo.flux_ref;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         torque_ref_reg <= RST_WORD;
      end else if (take_ref) begin
         torque_ref_reg <= algo.torque_ref;
      end
   end

   // ****************************************
   // initial speed and position detection
   // ****************************************
   fam_state_code #(
      .LAST_CODE(SD_FAULT),
      .DONE_CODE(SD_COMPLETE),
      .FAULT_CODE(SD_FAULT)
   ) u_sd_state (
      .pclk(pclk),
      .presetn(presetn),
      .load(take_sd),
      .code_in(algo.sd_state),
      .code_reg(sd_state_reg),
      .done(speed_detect_done),
      .error(speed_detect_error)
   );

   fam_magnitude u_sd_speed (
      .pclk(pclk),
      .presetn(presetn),
      .load(take_sd),
      .value_in(algo.sd_speed),
      .mag_reg(sd_speed_reg)
   );

   fam_state_code #(
      .LAST_CODE(PD_FAULT),
      .DONE_CODE(PD_COMPLETE),
      .FAULT_CODE(PD_FAULT)
   ) u_pd_state (
      .pclk(pclk),
      .presetn(presetn),
      .load(take_pd),
      .code_in(algo.pd_state),
      .code_reg(pd_state_reg),
      .done(position_detect_done),
      .error(position_detect_error)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_angle_reg <= RST_WORD;
      end else if (take_pd) begin
         pd_angle_reg <= algo.pd_angle;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   read_ref_a: assert property (
      setup && !pwrite && hit[SLOT_CL_REF] ##1 access
      |-> prdata == $past(cl_ref_reg, 1))
      else $error("closed-loop reference read returned wrong data");

   speed_mode_a: assert property (
      take_ref && algo.mode == MODE_SPEED
      |=> cl_ref_reg == $past(algo.speed_ref))
      else $error("speed reference not captured");

   power_mode_a: assert property (
      take_ref && algo.mode == MODE_POWER
      |=> cl_ref_reg == $past(algo.power_ref))
      else $error("power reference not captured");

   current_mode_a: assert property (
      take_ref && algo.mode == MODE_CURRENT
      |=> cl_ref_reg == $past(algo.current_ref))
      else $error("current reference not captured");

   flux_ref_a: assert property (
      ##1 $changed(flux_ref_reg) |-> $past(take_ref)
      && flux_ref_reg == $past(algo.flux_ref))
      else $error("flux reference changed without a sample");

   torque_ref_a: assert property (
      take_ref |=> torque_ref_reg == $past(algo.torque_ref))
      else $error("torque reference not captured");

   sd_code_a: assert property (
      take_sd && algo.sd_state > SD_FAULT |=> sd_state_reg == SD_FAULT
      ##0 speed_detect_error && !speed_detect_done)
      else $error("bad speed detection code not shown as fault");

   sd_speed_a: assert property (
      take_sd |=> sd_speed_reg == ($past(algo.sd_speed[31])
      ? 32'h0000_0000 - $past(algo.sd_speed) : $past(algo.sd_speed)))
      else $error("speed detection magnitude wrong");

   pd_code_a: assert property (
      take_pd && algo.pd_state <= PD_FAULT |=> pd_state_reg == $past(algo.pd_state))
      else $error("position detection code not captured");

   pd_end_a: assert property (
      position_detect_done == (pd_state_reg == PD_COMPLETE)
      && position_detect_error == (pd_state_reg == PD_FAULT) && pd_state_reg <= PD_FAULT)
      else $error("position detection end flags wrong");

   pd_angle_a: assert property (
      take_pd |=> pd_angle_reg == $past(algo.pd_angle) [*1] ##1 1'b1)
      else $error("position angle not captured");

   ro_write_a: assert property (
      access && pwrite && !hit[SLOT_CTRL] && !take_ref && !take_sd && !take_pd
      |=> $stable(cl_ref_reg) && $stable(sd_speed_reg) && $stable(pd_angle_reg)
      && $stable(freeze_reg))
      else $error("write disturbed a monitor register");

   freeze_hold_a: assert property (
      freeze_reg && !ctrl_wr |=> $stable(cl_ref_reg) [*2])
      else $error("reference moved while frozen");

   ref_read_c: cover property (setup && !pwrite && hit[SLOT_CL_REF] ##1 access);
   sd_done_c: cover property (speed_detect_done);
   pd_fault_c: cover property (position_detect_error);
   freeze_c: cover property (ctrl_wr && pwdata[CTRL_FREEZE_BIT]);
   unmapped_c: cover property (access && pslverr);

endmodule : fam_monitor_regs

/* tb/fam_monitor_regs_test.sv */
// self-checking apb testbench for the algorithm monitor register bank
`timescale 1ns/100ps
module fam_monitor_regs_test;
   import fam_pkg::*;

   // ****************************************
   // signals
   // ****************************************
   logic pclk, presetn, psel, penable, pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic pready, pslverr;
   fam_algo_type algo;
   logic sd_done, sd_err, pd_done, pd_err;
   int error_cnt, checked, cycles;
   logic [31:0] d;
   logic e;
   logic [31:0] spd [3] = '{32'hffff_fff0, 32'h8000_0000, 32'h1234_5678};
   logic [31:0] now_val [7];

   fam_monitor_regs DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .algo(algo), .speed_detect_done(sd_done),
      .speed_detect_error(sd_err), .position_detect_done(pd_done),
      .position_detect_error(pd_err)
   );

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // a hung handshake ends the run through the same closing report
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt++;
         test_done();
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk

   // data and error are taken at the rising edge that samples pready high;
   // a slave that never answers is left to the bench timeout
   task xfer(input logic wr, input logic [13:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task rd(input logic [11:0] idx, input logic [31:0] exp, input logic exp_err);
      xfer(1'b0, {idx, 2'b00}, 32'h0);
      chk(d, exp);
      chk({31'h0, e}, {31'h0, exp_err});
   endtask : rd

   task wr(input logic [11:0] idx, input logic [31:0] v);
      xfer(1'b1, {idx, 2'b00}, v);
      chk({31'h0, e}, 32'h0);
   endtask : wr

   // v is {position, speed detection, reference} valid pulses
   task sample(input logic [2:0] v);
      @(posedge pclk);
      algo.ref_valid <= v[0];
      algo.sd_valid <= v[1];
      algo.pd_valid <= v[2];
      @(posedge pclk);
      algo.ref_valid <= 1'b0;
      algo.sd_valid <= 1'b0;
      algo.pd_valid <= 1'b0;
   endtask : sample

   function automatic logic [31:0] mag(input logic [31:0] v);
      return v[31] ? ~v + 32'h1 : v;
   endfunction : mag

   task test_done;
      $display("checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   // ****************************************
   // tests
   // ****************************************
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      algo = '0;
      error_cnt = 0;
      checked = 0;
      cycles = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < NREG; i++) rd(REG_IDX[i], 32'h0, 1'b0);
      chk({28'h0, sd_done, sd_err, pd_done, pd_err}, 32'h0);
      $display("test reset values done");
      algo.speed_ref <= 32'hf000_0001;
      algo.power_ref <= 32'h0800_0002;
      algo.current_ref <= 32'h8000_0003;
      algo.mode <= 2'h0;
      sample(3'b001);
      rd(IDX_CL_REF, 32'hf000_0001, 1'b0);
      algo.mode <= 2'h1;
      sample(3'b001);
      rd(IDX_CL_REF, 32'h0800_0002, 1'b0);
      algo.mode <= 2'h2;
      sample(3'b001);
      rd(IDX_CL_REF, 32'h8000_0003, 1'b0);
      algo.mode <= 2'h3;
      algo.flux_ref <= 32'hfff0_0000;
      algo.torque_ref <= 32'h7fff_ffff;
      sample(3'b001);
      rd(IDX_CL_REF, 32'h8000_0003, 1'b0);
      rd(IDX_FLUX_REF, 32'hfff0_0000, 1'b0);
      rd(IDX_TORQUE_REF, 32'h7fff_ffff, 1'b0);
      rd(IDX_STATUS, 32'h0000_0300, 1'b0);
      $display("test reference modes done");
      for (int c = 0; c < 8; c++) begin
         algo.sd_state <= c[15:0];
         sample(3'b010);
         rd(IDX_SD_STATE, (c > 6) ? 32'h6 : c, 1'b0);
         chk({30'h0, sd_done, sd_err}, {30'h0, c == 5, c >= 6});
      end
      for (int i = 0; i < 3; i++) begin
         algo.sd_speed <= spd[i];
         sample(3'b010);
         rd(IDX_SD_SPEED, mag(spd[i]), 1'b0);
      end
      $display("test speed detection done");
      for (int c = 0; c < 14; c++) begin
         algo.pd_state <= c[15:0];
         algo.pd_angle <= 32'hd000_0000 + c;
         sample(3'b100);
         rd(IDX_PD_STATE, (c > 12) ? 32'hc : c, 1'b0);
         rd(IDX_PD_ANGLE, 32'hd000_0000 + c, 1'b0);
         chk({30'h0, pd_done, pd_err}, {30'h0, c == 11, c >= 12});
      end
      $display("test position detection done");
      now_val = '{32'h8000_0003, 32'hfff0_0000, 32'h7fff_ffff, 32'h6, 32'h1234_5678,
         32'hc, 32'hd000_000d};
      for (int i = 0; i < 7; i++) wr(REG_IDX[i], 32'hffff_ffff);
      for (int i = 0; i < 7; i++) rd(REG_IDX[i], now_val[i], 1'b0);
      $display("test read-only writes done");
      wr(IDX_CTRL, 32'h1);
      rd(IDX_CTRL, 32'h1, 1'b0);
      rd(IDX_STATUS, 32'h0000_031a, 1'b0);
      algo.mode <= 2'h0;
      algo.speed_ref <= 32'h1111_1111;
      algo.sd_state <= 16'h0005;
      sample(3'b111);
      rd(IDX_CL_REF, 32'h8000_0003, 1'b0);
      rd(IDX_SD_STATE, 32'h6, 1'b0);
      wr(IDX_CTRL, 32'h0);
      sample(3'b111);
      rd(IDX_CL_REF, 32'h1111_1111, 1'b0);
      rd(IDX_SD_STATE, 32'h5, 1'b0);
      chk({31'h0, sd_done}, 32'h1);
      $display("test freeze done");
      rd(12'h001, 32'h0, 1'b1);
      xfer(1'b0, 14'h1742, 32'h0);
      chk(d, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("test unmapped access done");
      test_done();
   end

endmodule : fam_monitor_regs_test
